// *** pkg/ldme_pkg.sv ***
// Constants for the LCD display mode engine
package ldme_pkg;
  localparam logic [7:0] OFS_MODE   = 8'h00;
  localparam logic [7:0] OFS_HDISP  = 8'h04;
  localparam logic [7:0] OFS_MAXRAS = 8'h08;
  localparam logic [7:0] OFS_VWIDTH = 8'h0C;
  localparam logic [7:0] OFS_STRAS  = 8'h10;
  localparam logic [7:0] OFS_STADDR = 8'h14;
  localparam logic [7:0] OFS_CURADR = 8'h18;
  localparam logic [7:0] OFS_CURRAS = 8'h1C;
  localparam logic [7:0] OFS_DUTY   = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam int MB_AT    = 0;
  localparam int MB_BLE   = 1;
  localparam int MB_WIDE  = 2;
  localparam int MB_GRAPH = 3;
  localparam int MB_ON    = 4;
  localparam int AB_REV   = 11;
  localparam int AB_CUR   = 12;
  localparam int AB_BLK   = 13;
  localparam int AB_BW    = 14;
  localparam int AB_BB    = 15;
  localparam int CE_LSB   = 8;
  localparam logic [4:0] RST_MODE   = 5'h00;
  localparam logic [7:0] RST_HDISP  = 8'h50;
  localparam logic [4:0] RST_MAXRAS = 5'h07;
  localparam logic [7:0] RST_VWIDTH = 8'h50;
  localparam logic [8:0] RST_DUTY   = 9'h0C7;
  localparam logic [8:0] REF_LAST   = 9'h00F;
  localparam logic [4:0] REF_COUNT  = 5'h10;
  localparam logic [1:0] SK_ONE     = 2'h2;
  localparam logic [1:0] SK_TWO     = 2'h1;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_DEC   = 2'h3;
endpackage

// *** tb/ldme_engine_bench.sv ***
// Self-checking bench for the display mode engine
`timescale 1ns/1ps
module ldme_engine_bench;
  logic clk = 1'b0, link_clk = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic graphic_select_pin = 1'b0, wide_pin = 1'b0, attribute_select_pin = 1'b0;
  logic display_on_pin = 1'b0, skew_select_low = 1'b0, skew_select_high = 1'b0;
  logic [15:0] fill_word = 16'h0;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [7:0] char_code_inputs, upper_memory_inputs;
  wire logic [15:0] memory_address_out, display_data_out;
  wire logic [4:0] raster_address_out;
  wire logic row_latch_clock, pixel_shift_clock, display_timing_out, cursor_display_out;
  wire logic data_is_word, reverse_out, blink_out, blank_white_out, blank_black_out;
  wire logic cursor_attr_out;
  int fails = 0, comparisons = 0, chg = 0, rcnt = 0, tcnt = 0, dly = 0, cur_seen = 0;
  logic [15:0] q[$], start, lstart, la;
  logic [4:0] rq[$], lras;
  int cq[$];
  logic rec = 1'b0, chk = 1'b0, gmode = 1'b0, prlc = 1'b0, pdt = 1'b0, first = 1'b1;
  logic pcu = 1'b0, acur = 1'b0;
  logic [20:0] exp_v, msk_v;
  logic [7:0] vw, lastref;
  ldme_engine DUT (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .link_clk, .graphic_select_pin, .wide_pin, .attribute_select_pin, .display_on_pin,
    .skew_select_low, .skew_select_high, .char_code_inputs, .upper_memory_inputs,
    .memory_address_out, .raster_address_out, .row_latch_clock, .pixel_shift_clock,
    .display_timing_out, .cursor_display_out, .display_data_out, .data_is_word, .reverse_out,
    .blink_out, .blank_white_out, .blank_black_out, .cursor_attr_out);
  ldme_mem_model mem (.link_clk, .row_latch_clock, .cursor_display_out, .fill_word,
    .char_code_inputs, .upper_memory_inputs);
  initial forever #50 clk = ~clk;
  initial begin
    #7;
    forever #24 link_clk = ~link_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] ev, input string m);
    comparisons++;
    if (seen !== ev) begin
      fails++;
      $display("[FAIL] %0t %s: got %h want %h", $time, m, seen, ev);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    check(s_axi_bresp, er, "bresp");
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, mk, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    check(s_axi_rdata & mk, ed, "rdata");
    check(s_axi_rresp, er, "rresp");
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // Line monitor in the link domain: refresh, line starts, timing delay, data
  always @(posedge link_clk) begin
    if (row_latch_clock) begin
      check(memory_address_out[15:8], 8'h00, "refresh high byte");
      if (!first && ce)
        check(memory_address_out[7:0], 8'(lastref + 8'h01), "refresh step");
      lastref = memory_address_out[7:0];
      first = 1'b0;
      rcnt = prlc ? rcnt + 1 : 1;
      if (!prlc && rec) begin
        q.push_back(lstart);
        rq.push_back(lras);
        cq.push_back(chg);
      end
    end else begin
      if (prlc) begin
        check(rcnt, 16, "refresh slots");
        chg = 0;
        tcnt = 0;
      end
      if (memory_address_out[15:8] != 8'h00 && memory_address_out !== la) begin
        if (chg == 0) lstart = memory_address_out;
        if (chg == 0) lras = raster_address_out;
        chg++;
        la = memory_address_out;
      end
      if (!display_timing_out) tcnt++;
      else if (!pdt) dly = tcnt;
    end
    if (chk && pdt && display_timing_out) check({data_is_word, display_data_out, reverse_out,
      blink_out, blank_white_out, blank_black_out} & msk_v, exp_v, "data");
    if (chk && pdt && display_timing_out)
      check(cursor_attr_out, acur && pcu, "cursor loopback");
    if (chk) check(pixel_shift_clock, display_timing_out, "shift clock");
    if (chk && gmode) check(cursor_display_out, 1'b0, "cursor in graphic");
    if (cursor_display_out) cur_seen++;
    prlc = row_latch_clock;
    pdt = display_timing_out;
    pcu = cursor_display_out;
  end
  // k: 0 overlay, 1 attributes, 2 graphic; rep 0 skips the row walk
  task automatic phase(input logic [4:0] m, sr, input logic atp, input int rep, nchg, k);
    logic [7:0] lo, hi;
    int i0;
    lo = 8'($urandom) | 8'h10;
    hi = 8'($urandom) & 8'hEF;
    fill_word <= {hi, lo};
    attribute_select_pin <= atp;
    axw(ldme_pkg::OFS_STRAS, 32'(sr), ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_MODE, 32'(m), ldme_pkg::RESP_OKAY);
    exp_v = (k == 0) ? {9'h000, lo | hi, 4'h0} : (k == 1) ?
      {9'h000, lo, hi[3], hi[5], hi[6], hi[7]} : {1'b1, hi, lo, 4'h0};
    msk_v = 21'h1FFFFF;
    gmode = (k == 2);
    acur = (k == 1);
    repeat (40) @(posedge clk);
    q.delete();
    rq.delete();
    cq.delete();
    cur_seen = 0;
    chk = 1'b1;
    rec = 1'b1;
    repeat (20000) if (q.size() < 12) @(posedge clk);
    rec = 1'b0;
    chk = 1'b0;
    for (int i = 0; i < cq.size(); i++) check(cq[i], nchg, "fetches per line");
    if (k != 2) check(cur_seen > 0, 1, "cursor shown");
    i0 = 0;
    for (int i = q.size() - 1; i > 0; i--) if (q[i] === start && q[i-1] !== start) i0 = i;
    check(i0 > 0, 1, "frame start");
    if (i0 > 0) check(rq[i0], (k == 2) ? 5'h00 : sr, "start raster");
    for (int j = 0; rep > 0 && i0 > 0 && i0 + j < q.size(); j++) begin
      check(q[i0+j], 16'(start + ((j % 4) / rep) * vw), "row address");
      check(rq[i0+j], 5'((j % 4) % rep), "raster");
    end
  endtask
  initial begin
    logic [4:0] m;
    logic [3:0] p;
    int d[3];
    logic [15:0] fa;
    void'($urandom(32'h1BD97ADD));
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rchk(ldme_pkg::OFS_HDISP, 32'h50, 32'hFF, ldme_pkg::RESP_OKAY);
    rchk(ldme_pkg::OFS_MAXRAS, 32'h07, 32'h1F, ldme_pkg::RESP_OKAY);
    rchk(ldme_pkg::OFS_VWIDTH, 32'h50, 32'hFF, ldme_pkg::RESP_OKAY);
    rchk(ldme_pkg::OFS_DUTY, 32'hC7, 32'h1FF, ldme_pkg::RESP_OKAY);
    rchk(8'h40, 32'h0, 32'hFFFFFFFF, ldme_pkg::RESP_DEC);
    axw(8'h44, 32'h1, ldme_pkg::RESP_DEC);
    axw(8'h02, 32'h1, ldme_pkg::RESP_DEC);
    repeat (4) begin
      m = 5'($urandom);
      p = 4'($urandom);
      {display_on_pin, graphic_select_pin, wide_pin, attribute_select_pin} <= p;
      axw(ldme_pkg::OFS_MODE, 32'(m), ldme_pkg::RESP_OKAY);
      repeat (10) @(posedge clk);
      rchk(ldme_pkg::OFS_STATUS, 32'(m | {p[3:1], 1'b0, p[0]}), 32'h1F,
        ldme_pkg::RESP_OKAY);
    end
    {display_on_pin, graphic_select_pin, wide_pin, attribute_select_pin} <= 4'h0;
    vw = 8'(5 + $urandom % 16);
    start = {4'h1, 12'($urandom)};
    axw(ldme_pkg::OFS_HDISP, 32'h4, ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_DUTY, 32'h3, ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_MAXRAS, 32'h1, ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_VWIDTH, 32'(vw), ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_STADDR, 32'(start), ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_CURADR, 32'(start), ldme_pkg::RESP_OKAY);
    axw(ldme_pkg::OFS_CURRAS, 32'h0100, ldme_pkg::RESP_OKAY);
    phase(5'h10, 5'h0, 1'b0, 2, 4, 0);
    phase(5'h12, 5'h1, 1'b1, 0, 4, 1);
    phase(5'h17, 5'h0, 1'b0, 2, 2, 1);
    phase(5'h1D, 5'h0, 1'b0, 1, 4, 2);
    phase(5'h18, 5'h1, 1'b0, 2, 4, 2);
    axw(ldme_pkg::OFS_MODE, 32'h10, ldme_pkg::RESP_OKAY);
    // Inhibited skew code never applied
    for (int c = 0; c < 3; c++) begin
      {skew_select_low, skew_select_high} <= (c == 0) ? 2'b00 : (c == 1) ? 2'b10 : 2'b01;
      repeat (300) @(posedge clk);
      d[c] = dly;
    end
    check(d[1], d[0] + 1, "skew one");
    check(d[2], d[0] + 2, "skew two");
    // Enable low must freeze the link side and close the bus
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    fa = memory_address_out;
    repeat (20) @(posedge clk);
    check(memory_address_out, fa, "frozen address");
    check(s_axi_arready, 1'b0, "frozen ready");
    print_verdict();
  end
  initial begin
    #2000000;
    fails++;
    print_verdict();
  end
endmodule // ldme_engine_bench

// *** tb/ldme_mem_model.sv ***
// Display memory model feeding the engine's memory data inputs
`timescale 1ns/1ps
module ldme_mem_model (
  input  wire logic        link_clk,
  input  wire logic        row_latch_clock,
  input  wire logic        cursor_display_out,
  input  wire logic [15:0] fill_word,
  output      logic [7:0]  char_code_inputs,
  output      logic [7:0]  upper_memory_inputs
);
  // Answers within the slot; refresh slots fetch nothing, so the bus shows the inverse
  assign char_code_inputs = row_latch_clock ? ~fill_word[7:0] : fill_word[7:0];
  assign upper_memory_inputs = row_latch_clock ? ~fill_word[15:8] :
                               {fill_word[15:13], cursor_display_out, fill_word[11:8]};
endmodule // ldme_mem_model

// *** verilog/ldme_engine.sv ***
// Display mode engine: register slave, config crossing and link logic
`timescale 1ns/1ps
module ldme_engine #(
  parameter int ADDR_W = 8
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              ce,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  output      logic [31:0]       s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              link_clk,
  input  wire logic              graphic_select_pin,
  input  wire logic              wide_pin,
  input  wire logic              attribute_select_pin,
  input  wire logic              display_on_pin,
  input  wire logic              skew_select_low,
  input  wire logic              skew_select_high,
  input  wire logic [7:0]        char_code_inputs,
  input  wire logic [7:0]        upper_memory_inputs,
  output      logic [15:0]       memory_address_out,
  output      logic [4:0]        raster_address_out,
  output      logic              row_latch_clock,
  output      logic              pixel_shift_clock,
  output      logic              display_timing_out,
  output      logic              cursor_display_out,
  output      logic [15:0]       display_data_out,
  output      logic              data_is_word,
  output      logic              reverse_out,
  output      logic              blink_out,
  output      logic              blank_white_out,
  output      logic              blank_black_out,
  output      logic              cursor_attr_out
);
  localparam int CFG_W = 82;

  if (ADDR_W < 8) begin : g_bad_addr
    $error("ADDR_W must be at least 8");
  end

  function automatic logic hit(input logic [7:0] a);
    hit = (a[1:0] == 2'h0) && (a <= ldme_pkg::OFS_STATUS);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Register file, system clock side
  logic [4:0]  mode_r;
  logic [7:0]  hdisp_r;
  logic [4:0]  maxras_r;
  logic [7:0]  vwidth_r;
  logic [4:0]  stras_r;
  logic [15:0] staddr_r;
  logic [15:0] curadr_r;
  logic [15:0] curras_r;
  logic [8:0]  duty_r;
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  awa_r;
  logic [31:0] wd_r;
  logic [3:0]  ws_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  logic [3:0]  ps1_r;
  logic [3:0]  ps2_r;
  logic        req_r;
  logic        ack1_r;
  logic        ack2_r;
  logic        seen_r;
  logic [CFG_W-1:0] hold_r;

  wire        do_wr = aw_got_r && w_got_r && !bvalid_r;
  wire [7:0]  ara   = s_axi_araddr[7:0];
  wire [4:0]  pin_mode = {ps2_r[3], ps2_r[2], ps2_r[0], 1'b0, ps2_r[1]};
  wire [4:0]  eff_sys  = mode_r | pin_mode;
  wire        busy     = req_r != ack2_r;
  wire [31:0] rd_word =
    (ara == ldme_pkg::OFS_MODE)   ? {27'h0, mode_r} :
    (ara == ldme_pkg::OFS_HDISP)  ? {24'h0, hdisp_r} :
    (ara == ldme_pkg::OFS_MAXRAS) ? {27'h0, maxras_r} :
    (ara == ldme_pkg::OFS_VWIDTH) ? {24'h0, vwidth_r} :
    (ara == ldme_pkg::OFS_STRAS)  ? {27'h0, stras_r} :
    (ara == ldme_pkg::OFS_STADDR) ? {16'h0, staddr_r} :
    (ara == ldme_pkg::OFS_CURADR) ? {16'h0, curadr_r} :
    (ara == ldme_pkg::OFS_CURRAS) ? {16'h0, curras_r} :
    (ara == ldme_pkg::OFS_DUTY)   ? {23'h0, duty_r} :
    (ara == ldme_pkg::OFS_STATUS) ? {26'h0, busy, eff_sys} : 32'h0;
  wire [CFG_W-1:0] cfg_now = {mode_r, hdisp_r, maxras_r, vwidth_r, stras_r,
                              staddr_r, curadr_r, curras_r[12:8],
                              curras_r[4:0], duty_r};

  assign s_axi_awready = ce && !aw_got_r && !bvalid_r;
  assign s_axi_wready  = ce && !w_got_r && !bvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ce && !rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r  <= ldme_pkg::RESP_OKAY;
      awa_r    <= 8'h00;
      wd_r     <= 32'h0;
      ws_r     <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r <= 1'b1;
        awa_r    <= s_axi_awaddr[7:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r <= 1'b1;
        wd_r    <= s_axi_wdata;
        ws_r    <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r  <= hit(awa_r) ? ldme_pkg::RESP_OKAY : ldme_pkg::RESP_DEC;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid_r <= 1'b0;
      rresp_r  <= ldme_pkg::RESP_OKAY;
      rdata_r  <= 32'h0;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_word;
        rresp_r  <= hit(ara) ? ldme_pkg::RESP_OKAY : ldme_pkg::RESP_DEC;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_r   <= ldme_pkg::RST_MODE;
      hdisp_r  <= ldme_pkg::RST_HDISP;
      maxras_r <= ldme_pkg::RST_MAXRAS;
      vwidth_r <= ldme_pkg::RST_VWIDTH;
      stras_r  <= 5'h00;
      staddr_r <= 16'h0000;
      curadr_r <= 16'h0000;
      curras_r <= 16'h0000;
      duty_r   <= ldme_pkg::RST_DUTY;
    end else if (ce && do_wr) begin
      case (awa_r)
        ldme_pkg::OFS_MODE:   mode_r   <= 5'(merge(16'(mode_r), wd_r, ws_r));
        ldme_pkg::OFS_HDISP:  hdisp_r  <= 8'(merge(16'(hdisp_r), wd_r, ws_r));
        ldme_pkg::OFS_MAXRAS: maxras_r <= 5'(merge(16'(maxras_r), wd_r, ws_r));
        ldme_pkg::OFS_VWIDTH: vwidth_r <= 8'(merge(16'(vwidth_r), wd_r, ws_r));
        ldme_pkg::OFS_STRAS:  stras_r  <= 5'(merge(16'(stras_r), wd_r, ws_r));
        ldme_pkg::OFS_STADDR: staddr_r <= merge(staddr_r, wd_r, ws_r);
        ldme_pkg::OFS_CURADR: curadr_r <= merge(curadr_r, wd_r, ws_r);
        ldme_pkg::OFS_CURRAS: curras_r <= merge(curras_r, wd_r, ws_r) & 16'h1F1F;
        ldme_pkg::OFS_DUTY:   duty_r   <= 9'(merge(16'(duty_r), wd_r, ws_r));
        default: ;
      endcase
    end
  end

  // Snapshot only when the link has acknowledged, so the held word is stable
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ps1_r  <= 4'h0;
      ps2_r  <= 4'h0;
      req_r  <= 1'b0;
      ack1_r <= 1'b0;
      ack2_r <= 1'b0;
      hold_r <= '0;
    end else if (ce) begin
      ps1_r  <= {display_on_pin, graphic_select_pin, attribute_select_pin, wide_pin};
      ps2_r  <= ps1_r;
      ack2_r <= ack1_r;
      ack1_r <= seen_r;
      if (!busy) begin
        hold_r <= cfg_now;
        req_r  <= !req_r;
      end
    end
  end

  // Link clock domain
  logic        lr1_r, lr2_r, lc1_r, lc2_r, rq1_r, rq2_r;
  logic [5:0]  lp1_r, lp2_r;
  logic [CFG_W-1:0] cfg_l_r;
  logic [8:0]  hc_r, ln_r;
  logic [4:0]  ra_r, rlrun_r;
  logic [15:0] rb_r, col_r;
  logic        half_r;
  logic [7:0]  ref_r;
  logic [2:0]  p0_r, p1_r, p2_r, st_r;
  logic [4:0]  l_mode, l_mr, l_sr, l_cs, l_ce;
  logic [7:0]  l_hd, l_vw;
  logic [15:0] l_sa, l_ca;
  logic [8:0]  l_duty;

  assign {l_mode, l_hd, l_mr, l_vw, l_sr, l_sa, l_ca, l_ce, l_cs, l_duty} = cfg_l_r;
  wire        lrst_n = lr2_r;
  wire        lce    = lc2_r;
  wire [4:0]  lpin   = {lp2_r[3], lp2_r[2], lp2_r[1], 1'b0, lp2_r[0]};
  wire [4:0]  eff    = l_mode | lpin;
  wire        graphic = eff[ldme_pkg::MB_GRAPH];
  wire        char_m = !graphic;
  wire        gr1    = graphic && eff[ldme_pkg::MB_AT];
  wire        gr2    = graphic && !eff[ldme_pkg::MB_AT];
  wire        wide_m = char_m && eff[ldme_pkg::MB_WIDE];
  wire        attr_m = char_m && eff[ldme_pkg::MB_AT];
  wire        or_m   = char_m && !eff[ldme_pkg::MB_AT];
  wire        on_m   = eff[ldme_pkg::MB_ON];
  wire [1:0]  skew   = lp2_r[5:4];
  wire        act    = hc_r < {1'b0, l_hd};
  wire        line_end  = hc_r == ({1'b0, l_hd} + ldme_pkg::REF_LAST);
  wire        frame_end = line_end && (ln_r >= l_duty);
  wire        row_end   = gr1 || (ra_r == l_mr);
  wire [15:0] addr_now  = rb_r + col_r;
  wire        cur_raw   = char_m && act && on_m && (addr_now == l_ca)
                          && (ra_r >= l_cs) && (ra_r <= l_ce);
  wire [2:0]  st_nxt = (skew == ldme_pkg::SK_ONE) ? p0_r :
                       (skew == ldme_pkg::SK_TWO) ? p1_r :
                       {cur_raw, act && on_m, act};
  wire [15:0] md = {upper_memory_inputs, char_code_inputs};
  wire [15:0] data_nxt = graphic ? md :
                         or_m ? {8'h00, md[7:0] | md[15:8]} :
                         {8'h00, md[7:0]};

  // Reset, enable and pins reach this domain through two flops
  always_ff @(posedge link_clk) begin
    lr1_r <= resetn;
    lr2_r <= lr1_r;
    lc1_r <= ce;
    lc2_r <= lc1_r;
    lp1_r <= {skew_select_low, skew_select_high, display_on_pin,
              graphic_select_pin, wide_pin, attribute_select_pin};
    lp2_r <= lp1_r;
    rq1_r <= req_r;
    rq2_r <= rq1_r;
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      seen_r  <= 1'b0;
      cfg_l_r <= {ldme_pkg::RST_MODE, ldme_pkg::RST_HDISP, ldme_pkg::RST_MAXRAS,
                  ldme_pkg::RST_VWIDTH, 5'h00, 16'h0000, 16'h0000, 10'h000,
                  ldme_pkg::RST_DUTY};
    end else if (lce && line_end && (rq2_r != seen_r)) begin
      // Settings land on a line boundary only, so no line is cut short
      seen_r  <= rq2_r;
      cfg_l_r <= hold_r;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      hc_r   <= 9'h000;
      ln_r   <= 9'h000;
      ra_r   <= 5'h00;
      rb_r   <= 16'h0000;
      col_r  <= 16'h0000;
      half_r <= 1'b0;
      ref_r  <= 8'h00;
    end else if (lce) begin
      hc_r <= line_end ? 9'h000 : hc_r + 9'h001;
      if (act) begin
        half_r <= wide_m && !half_r;
        if (!wide_m || half_r)
          col_r <= col_r + 16'h0001;
      end else begin
        ref_r <= ref_r + 8'h01;
      end
      if (line_end) begin
        col_r  <= 16'h0000;
        half_r <= 1'b0;
        if (frame_end) begin
          ln_r <= 9'h000;
          rb_r <= l_sa;
          ra_r <= char_m ? l_sr : 5'h00;
        end else begin
          ln_r <= ln_r + 9'h001;
          if (row_end) begin
            ra_r <= 5'h00;
            rb_r <= rb_r + {8'h00, l_vw};
          end else begin
            ra_r <= ra_r + 5'h01;
          end
        end
      end
    end
  end

  // Outputs; display data lags the shift clock by one slot
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      memory_address_out <= 16'h0000;
      raster_address_out <= 5'h00;
      row_latch_clock    <= 1'b0;
      p0_r <= 3'h0;
      p1_r <= 3'h0;
      st_r <= 3'h0;
      display_data_out <= 16'h0000;
      data_is_word     <= 1'b0;
      reverse_out      <= 1'b0;
      blink_out        <= 1'b0;
      blank_white_out  <= 1'b0;
      blank_black_out  <= 1'b0;
      cursor_attr_out  <= 1'b0;
    end else if (lce) begin
      memory_address_out <= act ? addr_now : {8'h00, ref_r};
      raster_address_out <= gr1 ? 5'h00 : ra_r;
      row_latch_clock    <= !act;
      p0_r <= {cur_raw, act && on_m, act};
      p1_r <= p0_r;
      st_r <= st_nxt;
      if (st_r[0]) begin
        display_data_out <= data_nxt;
        data_is_word     <= graphic;
        reverse_out      <= attr_m && md[ldme_pkg::AB_REV];
        blink_out        <= attr_m && eff[ldme_pkg::MB_BLE] && md[ldme_pkg::AB_BLK];
        blank_white_out  <= attr_m && md[ldme_pkg::AB_BW];
        blank_black_out  <= attr_m && md[ldme_pkg::AB_BB];
        cursor_attr_out  <= attr_m && md[ldme_pkg::AB_CUR];
      end
    end
  end

  assign cursor_display_out = st_r[2];
  assign display_timing_out = st_r[1];
  assign pixel_shift_clock  = st_r[0];

  always_ff @(posedge link_clk) begin
    if (!lrst_n)
      rlrun_r <= 5'h00;
    else if (lce)
      rlrun_r <= row_latch_clock ? rlrun_r + 5'h01 : 5'h00;
  end

  property p_no_cur_graph;
    @(posedge link_clk) disable iff (!lrst_n)
    (graphic && $past(graphic) && $past(graphic, 2) && $past(graphic, 3)) |-> !cursor_display_out;
  endproperty
  a_no_cur_graph: assert property (p_no_cur_graph) else $error("cursor in graphic");

  property p_mode_or;
    @(posedge link_clk) disable iff (!lrst_n)
    (lp2_r[2] || l_mode[ldme_pkg::MB_GRAPH]) |-> !cur_raw;
  endproperty
  a_mode_or: assert property (p_mode_or) else $error("graphic pin or bit ignored");

  property p_char_byte;
    @(posedge link_clk) disable iff (!lrst_n)
    ($past(pixel_shift_clock && char_m && lce)) |-> display_data_out[15:8] == 8'h00;
  endproperty
  a_char_byte: assert property (p_char_byte) else $error("char data not a byte");

  property p_gr1_data;
    @(posedge link_clk) disable iff (!lrst_n)
    ($past(pixel_shift_clock && gr1 && lce)) |->
      display_data_out == $past(md) && !reverse_out && raster_address_out == 5'h00;
  endproperty
  a_gr1_data: assert property (p_gr1_data) else $error("graphic 1 data wrong");

  property p_gr2_repeat;
    @(posedge link_clk) disable iff (!lrst_n)
    (lce && gr2 && line_end && !frame_end && ra_r != l_mr) |=> rb_r == $past(rb_r);
  endproperty
  a_gr2_repeat: assert property (p_gr2_repeat) else $error("graphic 2 row moved");

  property p_stride;
    @(posedge link_clk) disable iff (!lrst_n)
    (lce && line_end && !frame_end && row_end) |=>
      rb_r == $past(rb_r) + {8'h00, $past(l_vw)};
  endproperty
  a_stride: assert property (p_stride) else $error("row stride wrong");

  property p_smooth;
    @(posedge link_clk) disable iff (!lrst_n)
    (lce && frame_end && char_m) |=> ra_r == $past(l_sr);
  endproperty
  a_smooth: assert property (p_smooth) else $error("start raster not used");

  property p_wide;
    @(posedge link_clk) disable iff (!lrst_n)
    (lce && $past(lce) && act && wide_m && half_r) |=>
      memory_address_out == $past(memory_address_out);
  endproperty
  a_wide: assert property (p_wide) else $error("wide item not repeated");

  property p_or_data;
    @(posedge link_clk) disable iff (!lrst_n)
    ($past(pixel_shift_clock && or_m && lce)) |->
      display_data_out[7:0] == ($past(md[7:0]) | $past(md[15:8]))
      && !reverse_out && !blink_out && !blank_white_out && !blank_black_out;
  endproperty
  a_or_data: assert property (p_or_data) else $error("overlay data wrong");

  property p_attr;
    @(posedge link_clk) disable iff (!lrst_n)
    ($past(pixel_shift_clock && attr_m && lce)) |->
      reverse_out == $past(md[ldme_pkg::AB_REV])
      && blank_black_out == $past(md[ldme_pkg::AB_BB]);
  endproperty
  a_attr: assert property (p_attr) else $error("attribute decode wrong");

  property p_refresh;
    @(posedge link_clk) disable iff (!lrst_n)
    (lce && $fell(row_latch_clock)) |-> $past(rlrun_r) == ldme_pkg::REF_COUNT - 5'h01;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh run not 16");

  property p_skew2;
    @(posedge link_clk) disable iff (!lrst_n)
    (skew == ldme_pkg::SK_TWO && $past(skew) == ldme_pkg::SK_TWO
     && $past(skew, 2) == ldme_pkg::SK_TWO && lce && $past(lce) && $past(lce, 2))
      |=> pixel_shift_clock == $past(p0_r[0], 2) && display_timing_out == $past(p0_r[1], 2);
  endproperty
  a_skew2: assert property (p_skew2) else $error("two slot skew wrong");
endmodule // ldme_engine
